// *** hdl/rgsq_cfg.svh ***
// Purpose: offsets, reset values, field positions and timing counts
// Assumes: 20 MHz system clock, byte-wide host register port
// Notes:   definitions only
`ifndef RGSQ_CFG_SVH
`define RGSQ_CFG_SVH

`define RGSQ_NREF          4
`define RGSQ_SEL_W         2
`define RGSQ_CNT_W         15
`define RGSQ_MASK_W        4
`define RGSQ_MASK_GST_BIT  3

`define RGSQ_ADDR_DQ       8'h0b
`define RGSQ_ADDR_QS       8'h0c
`define RGSQ_ADDR_FRZ      8'h0d
`define RGSQ_ADDR_BF_HI    8'h10
`define RGSQ_ADDR_BF_LO    8'h11
`define RGSQ_ADDR_KM_HI    8'h12
`define RGSQ_ADDR_KM_LO    8'h13

`define RGSQ_DQ_RST        8'haa
`define RGSQ_QS_RST        8'h55
`define RGSQ_FRZ_RST       8'h00
`define RGSQ_BF_RST        16'h9c40
`define RGSQ_KM_RST        16'h0f30
`define RGSQ_FRZ_ON        8'h01

`define RGSQ_CLK_HZ        20000000
`define RGSQ_TICK_MS       1
`define RGSQ_DQ_MIN_MS     0
`define RGSQ_DQ_10_MS      10
`define RGSQ_DQ_50_MS      50
`define RGSQ_DQ_2S5_MS     2500

`endif

// *** hdl/rgsq_pkg.sv ***
// Purpose: shared types of the guard soak configuration block
// Assumes: constants live in rgsq_cfg.svh
// Notes:   none
package rgsq_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rgsq_host_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rgsq_host_rsp_t;

   typedef enum logic [1:0] {
      RGSQ_ST_QUAL,
      RGSQ_ST_DQ_WAIT,
      RGSQ_ST_DISQ,
      RGSQ_ST_Q_WAIT
   } rgsq_state_t;

endpackage

// *** hdl/rgsq_soak_timer.sv ***
// Purpose: per-reference guard soak timer, disqualify and requalify
// Assumes: tick_i is a one-cycle pulse every tick period
// Notes:   minimum delay acts at the next edge
`timescale 1ns/1ps
`include "rgsq_cfg.svh"
module rgsq_soak_timer import rgsq_pkg::*; (
   input  wire logic                    sys_clk_i,
   input  wire logic                    resetn_i,
   input  wire logic                    tick_i,
   input  wire logic                    alarm_i,
   input  wire logic [`RGSQ_SEL_W-1:0]  dq_sel_i,
   input  wire logic [`RGSQ_SEL_W-1:0]  q_sel_i,
   output logic                         qualified_o,
   output logic                         disq_evt_o
);

   localparam logic [`RGSQ_CNT_W-1:0] T_MIN = `RGSQ_CNT_W'(`RGSQ_DQ_MIN_MS / `RGSQ_TICK_MS);
   localparam logic [`RGSQ_CNT_W-1:0] T_10  = `RGSQ_CNT_W'(`RGSQ_DQ_10_MS / `RGSQ_TICK_MS);
   localparam logic [`RGSQ_CNT_W-1:0] T_50  = `RGSQ_CNT_W'(`RGSQ_DQ_50_MS / `RGSQ_TICK_MS);
   localparam logic [`RGSQ_CNT_W-1:0] T_2S5 = `RGSQ_CNT_W'(`RGSQ_DQ_2S5_MS / `RGSQ_TICK_MS);

   rgsq_state_t              state_r,  state_nxt;
   logic [`RGSQ_CNT_W-1:0]   cnt_r,    cnt_nxt;
   logic                     qual_r,   qual_nxt;
   logic                     evt_r,    evt_nxt;
   logic [`RGSQ_CNT_W-1:0]   dq_t;
   logic [`RGSQ_CNT_W-1:0]   q_t;
   logic [3:0]               mult;

   // disqualify delay in ticks
   function automatic logic [`RGSQ_CNT_W-1:0] dq_ticks(input logic [`RGSQ_SEL_W-1:0] sel);
      case (sel)
         2'h0:    dq_ticks = T_MIN;
         2'h1:    dq_ticks = T_10;
         2'h2:    dq_ticks = T_50;
         default: dq_ticks = T_2S5;
      endcase
   endfunction

   always_comb begin
      dq_t = dq_ticks(dq_sel_i);
      mult = 4'(({2'h0, q_sel_i} + 4'h1) << 1);
      q_t  = `RGSQ_CNT_W'(dq_t * mult);
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      qual_nxt  = qual_r;
      evt_nxt   = 1'b0;
      case (state_r)
         RGSQ_ST_QUAL: begin
            if (alarm_i) begin
               cnt_nxt = '0;
               if (dq_t == '0) begin
                  state_nxt = RGSQ_ST_DISQ;
                  qual_nxt  = 1'b0;
                  evt_nxt   = 1'b1;
               end else begin
                  state_nxt = RGSQ_ST_DQ_WAIT;
               end
            end
         end
         RGSQ_ST_DQ_WAIT: begin
            if (!alarm_i) begin
               state_nxt = RGSQ_ST_QUAL;
               cnt_nxt   = '0;
            end else if (cnt_r >= dq_t) begin
               state_nxt = RGSQ_ST_DISQ;
               qual_nxt  = 1'b0;
               evt_nxt   = 1'b1;
            end else if (tick_i) begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         RGSQ_ST_DISQ: begin
            if (!alarm_i) begin
               state_nxt = RGSQ_ST_Q_WAIT;
               cnt_nxt   = '0;
            end
         end
         RGSQ_ST_Q_WAIT: begin
            if (alarm_i) begin
               state_nxt = RGSQ_ST_DISQ;
            end else if (cnt_r >= q_t) begin
               state_nxt = RGSQ_ST_QUAL;
               qual_nxt  = 1'b1;
            end else if (tick_i) begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = RGSQ_ST_QUAL;
            cnt_nxt   = '0;
            qual_nxt  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state_r <= RGSQ_ST_QUAL;
         cnt_r   <= '0;
         qual_r  <= 1'b1;
         evt_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         qual_r  <= qual_nxt;
         evt_r   <= evt_nxt;
      end
   end

   assign qualified_o = qual_r;
   assign disq_evt_o  = evt_r;

   a_evt_drops_qual: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      disq_evt_o |-> !qualified_o) else $error("disqualify event while still qualified");
   a_fall_needs_alarm: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      $fell(qualified_o) |-> $past(alarm_i) && disq_evt_o) else $error("dropped without alarm");
   a_rise_needs_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(qualified_o) |-> $past(!alarm_i) && $past(state_r == RGSQ_ST_Q_WAIT))
      else $error("requalified while alarm present");
   a_min_delay_now: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_r == RGSQ_ST_QUAL && alarm_i && dq_sel_i == 2'h0) |=> !qualified_o)
      else $error("minimum delay not immediate");
   a_dq_wait_bound: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_r == RGSQ_ST_DQ_WAIT) |-> cnt_r <= dq_t) else $error("disqualify wait overran");
   a_q_wait_bound: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_r == RGSQ_ST_Q_WAIT && cnt_r >= q_t && !alarm_i) |=> qualified_o)
      else $error("qualify delay expired without requalify");
   c_disqualify: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $fell(qualified_o));
   c_requalify:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(qualified_o));
   c_cancel:     cover property (@(posedge sys_clk_i) disable iff (!resetn_i) state_r == RGSQ_ST_DQ_WAIT && !alarm_i);

endmodule

// *** hdl/rgsq_top.sv ***
// Purpose: guard soak register bank with per-reference soak timers
// Assumes: alarms arrive from other clock domains; host port is byte wide
// Notes:   16-bit registers are big-endian, high byte at lower address
//
// Contract
// - disqualify delay code: 00 minimum, 01 10 ms, 10 50 ms, 11 2.5 s.
// - either alarm starts disqualify delay; reference disqualified when it elapses.
// - reference n uses bits 2n+1:2n in both delay registers.
// - disqualify-delay register resets to 0xaa, 50 ms for all.
// - qualify delay starts after both alarms clear; requalify when it expires.
// - qualify code gives 2, 4, 6 or 8 times the disqualify delay.
// - qualify-delay register resets to 0x55, four times for all.
// - writing 0x01 to freeze register holds new sticky events; sticky clears still act.
// - writing 0x00 to freeze register resumes sticky status updates.
// - base frequency is 16-bit hertz at 0x10-0x11, reset 0x9c40.
// - wide registers big-endian: high byte at lower address.
// - bit 3 of each 4-bit failure mask gates soak failure into status.
`timescale 1ns/1ps
`include "rgsq_cfg.svh"
module rgsq_top import rgsq_pkg::*; #(
   parameter int TICK_CYCLES = `RGSQ_CLK_HZ / 1000 * `RGSQ_TICK_MS
) (
   input  wire logic                              sys_clk_i,
   input  wire logic                              resetn_i,
   input  wire rgsq_host_req_t                    host_req_i,
   output rgsq_host_rsp_t                         host_rsp_o,
   input  wire logic [`RGSQ_NREF-1:0]             coarse_frequency_alarm_i,
   input  wire logic [`RGSQ_NREF-1:0]             single_cycle_alarm_i,
   input  wire logic [`RGSQ_NREF*`RGSQ_MASK_W-1:0] ref_failure_mask_i,
   input  wire logic [`RGSQ_NREF-1:0]             sticky_clear_i,
   output logic [`RGSQ_NREF-1:0]                  ref_qualified_o,
   output logic [`RGSQ_NREF-1:0]                  sticky_on_read_status_o,
   output logic [`RGSQ_NREF-1:0]                  soak_fail_int_status_o,
   output logic [15:0]                            base_frequency_value_o,
   output logic [15:0]                            base_frequency_multiplier_o
);

   localparam int DIV_W = $clog2(TICK_CYCLES + 1);

   logic [7:0]               dq_r,   dq_nxt;
   logic [7:0]               qs_r,   qs_nxt;
   logic [7:0]               frz_r,  frz_nxt;
   logic [15:0]              bf_r,   bf_nxt;
   logic [15:0]              km_r,   km_nxt;
   rgsq_host_rsp_t           rsp_r,  rsp_nxt;
   logic [DIV_W-1:0]         div_r,  div_nxt;
   logic                     tick_r, tick_nxt;
   logic [`RGSQ_NREF-1:0]    stk_r,  stk_nxt;
   logic [`RGSQ_NREF-1:0]    pend_r, pend_nxt;
   logic [`RGSQ_NREF-1:0]    int_r,  int_nxt;
   logic [`RGSQ_NREF-1:0]    disq_evt;
   logic [`RGSQ_NREF-1:0]    alarm;
   logic [2*`RGSQ_NREF-1:0]  raw_in;
   logic [2*`RGSQ_NREF-1:0]  s1_r, s2_r, s3_r, filt_r, filt_nxt;
   logic                     frozen;

   // register read decode
   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] dq, input logic [7:0] qs,
                                           input logic [7:0] fz, input logic [15:0] bf, input logic [15:0] km);
      case (a)
         `RGSQ_ADDR_DQ:    reg_read = dq;
         `RGSQ_ADDR_QS:    reg_read = qs;
         `RGSQ_ADDR_FRZ:   reg_read = fz;
         `RGSQ_ADDR_BF_HI: reg_read = bf[15:8];
         `RGSQ_ADDR_BF_LO: reg_read = bf[7:0];
         `RGSQ_ADDR_KM_HI: reg_read = km[15:8];
         `RGSQ_ADDR_KM_LO: reg_read = km[7:0];
         default:          reg_read = 8'h00;
      endcase
   endfunction

   // host writes and reads
   always_comb begin
      dq_nxt  = dq_r;
      qs_nxt  = qs_r;
      frz_nxt = frz_r;
      bf_nxt  = bf_r;
      km_nxt  = km_r;
      rsp_nxt.valid = host_req_i.rd;
      rsp_nxt.data  = host_req_i.rd ? reg_read(host_req_i.addr, dq_r, qs_r, frz_r, bf_r, km_r) : rsp_r.data;
      if (host_req_i.wr) begin
         case (host_req_i.addr)
            `RGSQ_ADDR_DQ:    dq_nxt  = host_req_i.wdata;
            `RGSQ_ADDR_QS:    qs_nxt  = host_req_i.wdata;
            `RGSQ_ADDR_FRZ:   frz_nxt = host_req_i.wdata;
            `RGSQ_ADDR_BF_HI: bf_nxt  = {host_req_i.wdata, bf_r[7:0]};
            `RGSQ_ADDR_BF_LO: bf_nxt  = {bf_r[15:8], host_req_i.wdata};
            `RGSQ_ADDR_KM_HI: km_nxt  = {host_req_i.wdata, km_r[7:0]};
            `RGSQ_ADDR_KM_LO: km_nxt  = {km_r[15:8], host_req_i.wdata};
            default:          dq_nxt  = dq_r;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         dq_r  <= `RGSQ_DQ_RST;
         qs_r  <= `RGSQ_QS_RST;
         frz_r <= `RGSQ_FRZ_RST;
         bf_r  <= `RGSQ_BF_RST;
         km_r  <= `RGSQ_KM_RST;
         rsp_r <= '0;
      end else begin
         dq_r  <= dq_nxt;
         qs_r  <= qs_nxt;
         frz_r <= frz_nxt;
         bf_r  <= bf_nxt;
         km_r  <= km_nxt;
         rsp_r <= rsp_nxt;
      end
   end

   // tick divider
   always_comb begin
      tick_nxt = (div_r == DIV_W'(TICK_CYCLES - 1));
      div_nxt  = tick_nxt ? '0 : div_r + 1'b1;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   // alarm synchronisers: change accepted when stages two and three agree
   assign raw_in = {single_cycle_alarm_i, coarse_frequency_alarm_i};

   always_comb begin
      filt_nxt = filt_r;
      for (int i = 0; i < 2*`RGSQ_NREF; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            filt_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         filt_r <= '0;
      end else begin
         s1_r   <= raw_in;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   assign alarm = filt_r[`RGSQ_NREF-1:0] | filt_r[2*`RGSQ_NREF-1:`RGSQ_NREF];

   genvar g;
   generate
      for (g = 0; g < `RGSQ_NREF; g++) begin : g_ref
         rgsq_soak_timer u_timer (
            .sys_clk_i   (sys_clk_i),
            .resetn_i    (resetn_i),
            .tick_i      (tick_r),
            .alarm_i     (alarm[g]),
            .dq_sel_i    (dq_r[2*g+1:2*g]),
            .q_sel_i     (qs_r[2*g+1:2*g]),
            .qualified_o (ref_qualified_o[g]),
            .disq_evt_o  (disq_evt[g])
         );
      end
   endgenerate

   // sticky status with freeze, held events applied on release
   assign frozen = (frz_r == `RGSQ_FRZ_ON);

   always_comb begin
      if (frozen) begin
         stk_nxt  = stk_r & ~sticky_clear_i;
         pend_nxt = pend_r | disq_evt;
      end else begin
         stk_nxt  = (stk_r & ~sticky_clear_i) | disq_evt | pend_r;
         pend_nxt = '0;
      end
      for (int i = 0; i < `RGSQ_NREF; i++) begin
         int_nxt[i] = stk_nxt[i] & ref_failure_mask_i[i*`RGSQ_MASK_W + `RGSQ_MASK_GST_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         stk_r  <= '0;
         pend_r <= '0;
         int_r  <= '0;
      end else begin
         stk_r  <= stk_nxt;
         pend_r <= pend_nxt;
         int_r  <= int_nxt;
      end
   end

   assign host_rsp_o                  = rsp_r;
   assign sticky_on_read_status_o     = stk_r;
   assign soak_fail_int_status_o      = int_r;
   assign base_frequency_value_o      = bf_r;
   assign base_frequency_multiplier_o = km_r;

   a_reset_values: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> dq_r == `RGSQ_DQ_RST && qs_r == `RGSQ_QS_RST && bf_r == `RGSQ_BF_RST)
      else $error("register reset value wrong");
   a_freeze_holds: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (frozen && sticky_clear_i == '0) |=> stk_r == $past(stk_r)) else $error("sticky changed while frozen");
   a_release_applies: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (!frozen && pend_r != '0) |=> (stk_r & $past(pend_r)) == $past(pend_r))
      else $error("held event lost on release");
   a_hi_byte_first: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (host_req_i.wr && host_req_i.addr == `RGSQ_ADDR_BF_HI) |=> bf_r[15:8] == $past(host_req_i.wdata))
      else $error("high byte not at lower address");
   a_mask_gates: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      ##1 int_r == (stk_r & {ref_failure_mask_i[15], ref_failure_mask_i[11],
                             ref_failure_mask_i[7], ref_failure_mask_i[3]}) || $changed(ref_failure_mask_i))
      else $error("interrupt status not gated by mask");
   c_frozen_event: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) frozen && disq_evt != '0);
   c_read_back:    cover property (@(posedge sys_clk_i) disable iff (!resetn_i) host_rsp_o.valid);

endmodule

// *** verification/rgsq_host_model.sv ***
// Purpose: host model driving the byte-wide register port
// Assumes: requests change on the falling clock edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
`include "rgsq_cfg.svh"
module rgsq_host_model import rgsq_pkg::*; (
   input  wire logic           sys_clk_i,
   input  wire rgsq_host_rsp_t host_rsp_i,
   output rgsq_host_req_t      host_req_o
);
   localparam logic [15:0] BASE_TAB [4] = '{16'h1f40, 16'h9c40, 16'h61a8, 16'h03e8};
   localparam logic [15:0] MULT_TAB [4] = '{16'h0100, 16'h01e6, 16'h186a, 16'h0008};

   initial begin
      host_req_o = '0;
   end

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd8(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk_i);
      host_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      ok = host_rsp_i.valid;
      d  = host_rsp_i.data;
   endtask

   // high byte first at the lower address
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr8(a, v[15:8]);
      wr8(a + 8'h01, v[7:0]);
   endtask

   // full reference rate is programmed
   task automatic set_ref_rate(input int k);
      wr16(`RGSQ_ADDR_BF_HI, BASE_TAB[k]);
      wr16(`RGSQ_ADDR_KM_HI, MULT_TAB[k]);
   endtask

   // hold or resume sticky status updates by writing the freeze register
   task automatic freeze(input logic on);
      wr8(`RGSQ_ADDR_FRZ, on ? 8'h01 : 8'h00);
   endtask
endmodule

// *** verification/ref_guard_soak_qualify_config_test.sv ***
// Purpose: self-checking bench of the guard soak register bank
// Assumes: tick shortened to 4 clocks
// Notes:   random values from a bench lfsr
`timescale 1ns/1ps
`include "rgsq_cfg.svh"
module ref_guard_soak_qualify_config_test import rgsq_pkg::*;;
   localparam int TICK = 4;
   localparam logic [7:0] RA [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
   localparam logic [7:0] RE [8] = '{8'haa, 8'h55, 8'h00, 8'h9c, 8'h40, 8'h0f, 8'h30, 8'h00};
   logic           sys_clk     = 1'b0;
   logic           resetn      = 1'b0;
   rgsq_host_req_t host_req;
   rgsq_host_rsp_t host_rsp;
   logic [3:0]     cfa         = '0;
   logic [3:0]     sca         = '0;
   logic [3:0]     sclr        = '0;
   logic [15:0]    fmask       = '0;
   logic [3:0]     qual;
   logic [3:0]     sticky;
   logic [3:0]     intst;
   logic [15:0]    bfv;
   logic [15:0]    bfm;
   logic [31:0]    seed        = 32'hf30c;
   logic [7:0]     dqreg       = 8'haa;
   logic [7:0]     qsreg       = 8'h55;
   logic           frozen      = 1'b0;
   int             miscompares = 0;
   int             compares    = 0;

   always #25 sys_clk = ~sys_clk;

   rgsq_host_model u_host (
      .sys_clk_i  (sys_clk),
      .host_rsp_i (host_rsp),
      .host_req_o (host_req)
   );

   rgsq_top #(.TICK_CYCLES(TICK)) u_dut (
      .sys_clk_i                   (sys_clk),
      .resetn_i                    (resetn),
      .host_req_i                  (host_req),
      .host_rsp_o                  (host_rsp),
      .coarse_frequency_alarm_i    (cfa),
      .single_cycle_alarm_i        (sca),
      .ref_failure_mask_i          (fmask),
      .sticky_clear_i              (sclr),
      .ref_qualified_o             (qual),
      .sticky_on_read_status_o     (sticky),
      .soak_fail_int_status_o      (intst),
      .base_frequency_value_o      (bfv),
      .base_frequency_multiplier_o (bfm)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic int dq_ticks(input logic [1:0] c);
      return (c == 2'b00) ? 0 : (c == 2'b01) ? 10 : (c == 2'b10) ? 50 : 2500;
   endfunction

   task automatic end_sim();
      if (miscompares == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      u_host.rd8(a, d, ok);
      chk("read valid", 16'h0001, {15'h0000, ok});
      chk("read data", {8'h00, e}, {8'h00, d});
   endtask

   task automatic wait_qual(input int r, input logic v, input int lim, output int n);
      n = 0;
      while (qual[r] !== v && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      if (qual[r] !== v) begin
         miscompares++;
         $display("[FAIL] qualified wait expected %h seen %h", v, qual[r]);
         end_sim();
      end
   endtask

   task automatic soak(input int r, input logic [1:0] dc, input logic [1:0] qc, input int src);
      int n;
      int d;
      int lo;
      d = dq_ticks(dc) * TICK;
      lo = 2 * (qc + 1) * d;
      dqreg[2*r +: 2] = dc;
      qsreg[2*r +: 2] = qc;
      u_host.wr8(`RGSQ_ADDR_DQ, dqreg);
      u_host.wr8(`RGSQ_ADDR_QS, qsreg);
      if (src != 1) cfa[r] = 1'b1;
      if (src != 0) sca[r] = 1'b1;
      wait_qual(r, 1'b0, d + TICK + 12, n);
      chk("disqualify lower bound", 16'h0001, 16'(n >= d));
      chk("other refs", 16'(4'hf & ~(4'h1 << r)), 16'(qual & ~(4'h1 << r)));
      if (src == 2) begin
         cfa[r] = 1'b0;
         repeat (lo + TICK + 12) @(negedge sys_clk);
         chk("held by one alarm", 16'h0000, 16'(qual[r]));
      end
      cfa[r] = 1'b0;
      sca[r] = 1'b0;
      wait_qual(r, 1'b1, lo + TICK + 12, n);
      chk("qualify lower bound", 16'h0001, 16'(n >= lo));
      chk("sticky", 16'(!frozen), 16'(sticky[r]));
      chk("int status", 16'(!frozen & fmask[4*r+3]), 16'(intst[r]));
   endtask

   task automatic clear_sticky(input int r);
      sclr[r] = 1'b1;
      @(negedge sys_clk);
      sclr[r] = 1'b0;
      @(negedge sys_clk);
      chk("sticky cleared", 16'h0000, 16'(sticky[r]));
   endtask

   initial begin
      int n;
      repeat (10) @(negedge sys_clk);
      resetn = 1'b1;
      chk("qualified reset", 16'h000f, 16'(qual));
      chk("base reset", 16'h9c40, bfv);
      chk("multiple reset", 16'h0f30, bfm);
      chk("sticky reset", 16'h0000, 16'(sticky));
      for (int i = 0; i < 8; i++) begin
         rdchk(RA[i], RE[i]);
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         u_host.wr8(`RGSQ_ADDR_DQ, seed[7:0]);
         rdchk(`RGSQ_ADDR_DQ, seed[7:0]);
         u_host.wr8(`RGSQ_ADDR_QS, seed[15:8]);
         rdchk(`RGSQ_ADDR_QS, seed[15:8]);
         u_host.wr8(8'h20, seed[23:16]);
         rdchk(8'h20, 8'h00);
         u_host.set_ref_rate(int'(seed[25:24]));
         chk("base value", u_host.BASE_TAB[seed[25:24]], bfv);
         chk("multiple value", u_host.MULT_TAB[seed[25:24]], bfm);
         rdchk(`RGSQ_ADDR_BF_HI, u_host.BASE_TAB[seed[25:24]][15:8]);
      end
      seed = lfsr(seed);
      fmask = (seed[15:0] | 16'h0008) & 16'h7fff;
      for (int r = 0; r < 4; r++) begin
         seed = lfsr(seed);
         soak(r, 2'(r), (r == 3) ? 2'b00 : seed[1:0], r % 3);
         clear_sticky(r);
      end
      // alarm dropped inside the disqualify wait, then alarm back inside the qualify wait
      dqreg[1:0] = 2'b10;
      qsreg[1:0] = 2'b00;
      u_host.wr8(`RGSQ_ADDR_DQ, dqreg);
      u_host.wr8(`RGSQ_ADDR_QS, qsreg);
      cfa[0] = 1'b1;
      repeat (dq_ticks(2'b10) * TICK / 2) @(negedge sys_clk);
      cfa[0] = 1'b0;
      repeat (dq_ticks(2'b10) * TICK + 100) @(negedge sys_clk);
      chk("cancelled disqualify", 16'h0001, 16'(qual[0]));
      cfa[0] = 1'b1;
      wait_qual(0, 1'b0, dq_ticks(2'b10) * TICK + TICK + 12, n);
      cfa[0] = 1'b0;
      repeat (dq_ticks(2'b10) * TICK) @(negedge sys_clk);
      cfa[0] = 1'b1;
      repeat (20) @(negedge sys_clk);
      cfa[0] = 1'b0;
      wait_qual(0, 1'b1, 2 * dq_ticks(2'b10) * TICK + TICK + 12, n);
      chk("qualify restart", 16'h0001, 16'(n >= 2 * dq_ticks(2'b10) * TICK));
      u_host.freeze(1'b1);
      frozen = 1'b1;
      soak(1, 2'b00, 2'b11, 1);
      u_host.freeze(1'b0);
      frozen = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("sticky after release", 16'h0001, 16'(sticky[1]));
      end_sim();
   end
endmodule
